// file: design/lane_cfg_defs.svh
// Offsets, field positions and reset values of the lane and filter configuration slice
`ifndef LANE_CFG_DEFS_SVH
`define LANE_CFG_DEFS_SVH

// Register indexes; byte address is four times the index
`define IDX_PRBS_HPF 10'h039
`define IDX_PAIR_PAT 10'h03b
`define IDX_STATUS 10'h040
`define REG_RESET 16'h0000

// First register fields
`define PRBS_HI 15
`define PRBS_LO 12
`define PAT13_HI 11
`define PAT13_LO 9
`define PAT14_HI 8
`define PAT14_LO 6
`define K_HI 4
`define K_LO 1
`define HPF_EN 0
`define MASK_PRBS_HPF 16'hffdf

// Second register fields
`define PAIR_HI 11
`define PAIR_LO 8
`define PAT15_HI 7
`define PAT15_LO 5
`define PAT16_HI 4
`define PAT16_LO 2
`define MASK_PAIR_PAT 16'h0ffc

// Coefficient limits and pair numbering
`define K_MIN 4'h2
`define K_MAX 4'ha
`define PAIR_BASE13 6'h19
`define PAIR_BASE14 6'h1b
`define PAIR_BASE15 6'h1d
`define PAIR_BASE16 6'h1f

// Status bits
`define ST_K_RANGE 0
`define ST_RSV_WR 1
`define ST_IND 2
`define ST_16CH 3

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: design/lane_cfg_pkg.sv
// Types shared by the lane and filter configuration slice
package lane_cfg_pkg;
	typedef enum {rd_idle, rd_resp} rd_state_t;
	typedef logic [2:0] pattern_sel_t;
	typedef logic [5:0] pair_num_t;
	typedef logic [15:0] cfg_word_t;
endpackage

// file: design/lane_pattern_gate.sv
// Per-lane gating of PRBS enable and pattern select by independent selection
`timescale 1ns/1ps
`include "lane_cfg_defs.svh"
module lane_pattern_gate
	import lane_cfg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic independent_pattern_select,
	input wire logic prbs_en,
	input wire pattern_sel_t pattern_sel,
	output logic prbs_active,
	output logic pattern_active,
	output pattern_sel_t pattern_out
);
	// Per-lane settings count only under independent selection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prbs_active <= 1'b0;
			pattern_active <= 1'b0;
			pattern_out <= 3'h0;
		end
		else
		begin
			prbs_active <= prbs_en & independent_pattern_select;
			pattern_active <= independent_pattern_select;
			pattern_out <= independent_pattern_select ? pattern_sel : 3'h0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_prbs_gate_lane: assert property (prbs_active |-> $past(independent_pattern_select))
		else $error("lane PRBS active without independent selection");
	chk_pattern_gate_lane: assert property ((pattern_out != 3'h0) |->
		$past(independent_pattern_select) && pattern_out == $past(pattern_sel))
		else $error("lane pattern not gated by independent selection");
endmodule

// file: design/input_pair_steer.sv
// Input pair steering of one converter in 16-input mode
`timescale 1ns/1ps
`include "lane_cfg_defs.svh"
module input_pair_steer
	import lane_cfg_pkg::*;
#(
	parameter pair_num_t PAIR_BASE = `PAIR_BASE13
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sixteen_input_mode,
	input wire logic pair_sel,
	output pair_num_t pair_num
);
	// Zero means the steering bit is idle outside 16-input mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pair_num <= 6'h00;
		else if (sixteen_input_mode)
			pair_num <= PAIR_BASE + pair_num_t'(pair_sel);
		else
			pair_num <= 6'h00;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_pair_steer_pick: assert property (sixteen_input_mode |=>
		pair_num == PAIR_BASE + pair_num_t'($past(pair_sel)))
		else $error("converter steered to wrong input pair");
endmodule

// file: design/lane_hpf_cfg_regs.sv
// AXI4-Lite register slice for lanes 13-16 patterns, group filter and input pairs
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "lane_cfg_defs.svh"

// Summary of operation
// - Four PRBS lane enables, gated by independent select
// - Lanes 13, 14 pattern selects in first register
// - Lanes 15, 16 pattern selects in second register
// - Bit 0 enables group filter, reset off
// - Coefficient k at bits 4-1, range 2-10
// - Coefficient acts only while filter enabled
// - Bit 11 picks pair 25 or 26
// - Bit 10 picks pair 27 or 28
// - Bit 9 picks pair 29 or 30
// - Bit 8 picks pair 31 or 32
module lane_hpf_cfg_regs
	import lane_cfg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic independent_pattern_select,
	input wire logic sixteen_input_mode,
	output logic [3:0] lane_prbs_active,
	output logic [3:0] lane_pattern_active,
	output pattern_sel_t test_pattern_sel_lane13,
	output pattern_sel_t test_pattern_sel_lane14,
	output pattern_sel_t test_pattern_sel_lane15,
	output pattern_sel_t test_pattern_sel_lane16,
	output logic highpass_enable_grp4,
	output logic [3:0] highpass_coeff_k_grp4,
	output pair_num_t input_pair_conv13,
	output pair_num_t input_pair_conv14,
	output pair_num_t input_pair_conv15,
	output pair_num_t input_pair_conv16
);
	cfg_word_t lane_prbs_pattern_hpf_ctrl;
	cfg_word_t input_pair_pattern_ctrl;
	logic rsv_write_seen;
	logic aw_got;
	logic w_got;
	logic [11:0] awaddr_q;
	cfg_word_t wdata_q;
	logic [1:0] wstrb_q;
	rd_state_t rd_state;

	// Write channel bookkeeping
	logic aw_hs;
	logic w_hs;
	logic do_write;
	logic next_aw_got;
	logic next_w_got;
	logic next_bvalid;
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign do_write = aw_got & w_got & ~s_axi_bvalid;
	assign next_aw_got = do_write ? 1'b0 : (aw_got | aw_hs);
	assign next_w_got = do_write ? 1'b0 : (w_got | w_hs);
	assign next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

	// Write decode, byte lanes and reserved-bit detection
	logic [9:0] wr_idx;
	logic wr_aligned;
	logic wr_hit_a;
	logic wr_hit_b;
	logic wr_hit_st;
	cfg_word_t wmask;
	cfg_word_t merged_a;
	cfg_word_t merged_b;
	logic rsv_hit;
	assign wr_idx = awaddr_q[11:2];
	assign wr_aligned = awaddr_q[1:0] == 2'h0;
	assign wr_hit_a = wr_aligned && wr_idx == `IDX_PRBS_HPF;
	assign wr_hit_b = wr_aligned && wr_idx == `IDX_PAIR_PAT;
	assign wr_hit_st = wr_aligned && wr_idx == `IDX_STATUS;
	assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	// Reserved bits are not stored, so they always read back zero
	assign merged_a = ((lane_prbs_pattern_hpf_ctrl & ~wmask) | (wdata_q & wmask))
		& `MASK_PRBS_HPF;
	assign merged_b = ((input_pair_pattern_ctrl & ~wmask) | (wdata_q & wmask))
		& `MASK_PAIR_PAT;
	assign rsv_hit = do_write && ((wr_hit_a && |(wdata_q & wmask & ~`MASK_PRBS_HPF))
		|| (wr_hit_b && |(wdata_q & wmask & ~`MASK_PAIR_PAT)));

	// Address and data are taken in either order, one write at a time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= `REG_RESET;
			wstrb_q <= 2'h0;
		end
		else
		begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			if (aw_hs)
				awaddr_q <= s_axi_awaddr;
			if (w_hs)
			begin
				wdata_q <= s_axi_wdata[15:0];
				wstrb_q <= s_axi_wstrb[1:0];
			end
		end
	end

	// Ready stays low while a response is pending, which paces writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= ~next_aw_got & ~next_bvalid;
			s_axi_wready <= ~next_w_got & ~next_bvalid;
			s_axi_bvalid <= next_bvalid;
			if (do_write)
				s_axi_bresp <= (wr_hit_a | wr_hit_b | wr_hit_st) ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	// Configuration registers, all fields reset to zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lane_prbs_pattern_hpf_ctrl <= `REG_RESET;
			input_pair_pattern_ctrl <= `REG_RESET;
		end
		else if (do_write)
		begin
			if (wr_hit_a)
				lane_prbs_pattern_hpf_ctrl <= merged_a;
			if (wr_hit_b)
				input_pair_pattern_ctrl <= merged_b;
		end
	end

	// Sticky reserved-write flag; a new event wins over a clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rsv_write_seen <= 1'b0;
		else if (rsv_hit)
			rsv_write_seen <= 1'b1;
		else if (do_write && wr_hit_st && wstrb_q[0] && wdata_q[`ST_RSV_WR])
			rsv_write_seen <= 1'b0;
	end

	// Coefficient outside 2..10 is kept but flagged for software
	logic [3:0] coeff_k;
	logic k_out_of_range;
	assign coeff_k = lane_prbs_pattern_hpf_ctrl[`K_HI:`K_LO];
	assign k_out_of_range = coeff_k < `K_MIN || coeff_k > `K_MAX;

	// Filter controls; k reaches the datapath only while enabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			highpass_enable_grp4 <= 1'b0;
			highpass_coeff_k_grp4 <= 4'h0;
		end
		else
		begin
			highpass_enable_grp4 <= lane_prbs_pattern_hpf_ctrl[`HPF_EN];
			highpass_coeff_k_grp4 <= lane_prbs_pattern_hpf_ctrl[`HPF_EN] ? coeff_k : 4'h0;
		end
	end

	// Read decode
	logic [9:0] rd_idx;
	logic rd_aligned;
	logic rd_hit_a;
	logic rd_hit_b;
	logic rd_hit_st;
	logic [31:0] rd_word;
	logic [3:0] status_bits;
	assign rd_idx = s_axi_araddr[11:2];
	assign rd_aligned = s_axi_araddr[1:0] == 2'h0;
	assign rd_hit_a = rd_aligned && rd_idx == `IDX_PRBS_HPF;
	assign rd_hit_b = rd_aligned && rd_idx == `IDX_PAIR_PAT;
	assign rd_hit_st = rd_aligned && rd_idx == `IDX_STATUS;
	assign status_bits = {sixteen_input_mode, independent_pattern_select,
		rsv_write_seen, k_out_of_range};
	assign rd_word = rd_hit_a ? {16'h0000, lane_prbs_pattern_hpf_ctrl}
		: rd_hit_b ? {16'h0000, input_pair_pattern_ctrl}
		: rd_hit_st ? {28'h0000000, status_bits}
		: 32'h00000000;

	// Read answers one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state <= rd_idle;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			case (rd_state)
				rd_idle:
				begin
					s_axi_arready <= ~(s_axi_arvalid & s_axi_arready);
					if (s_axi_arvalid & s_axi_arready)
					begin
						s_axi_rdata <= rd_word;
						s_axi_rresp <= (rd_hit_a | rd_hit_b | rd_hit_st) ? `RESP_OKAY : `RESP_SLVERR;
						s_axi_rvalid <= 1'b1;
						rd_state <= rd_resp;
					end
				end
				rd_resp:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						s_axi_arready <= 1'b1;
						rd_state <= rd_idle;
					end
				end
				default:
				begin
					rd_state <= rd_idle;
					s_axi_rvalid <= 1'b0;
					s_axi_arready <= 1'b0;
				end
			endcase
		end
	end

	// Lane gating, one instance per lane
	lane_pattern_gate u_gate13 (
		.aclk(aclk),
		.aresetn(aresetn),
		.independent_pattern_select(independent_pattern_select),
		.prbs_en(lane_prbs_pattern_hpf_ctrl[`PRBS_HI]),
		.pattern_sel(lane_prbs_pattern_hpf_ctrl[`PAT13_HI:`PAT13_LO]),
		.prbs_active(lane_prbs_active[0]),
		.pattern_active(lane_pattern_active[0]),
		.pattern_out(test_pattern_sel_lane13)
	);
	lane_pattern_gate u_gate14 (
		.aclk(aclk),
		.aresetn(aresetn),
		.independent_pattern_select(independent_pattern_select),
		.prbs_en(lane_prbs_pattern_hpf_ctrl[`PRBS_HI-1]),
		.pattern_sel(lane_prbs_pattern_hpf_ctrl[`PAT14_HI:`PAT14_LO]),
		.prbs_active(lane_prbs_active[1]),
		.pattern_active(lane_pattern_active[1]),
		.pattern_out(test_pattern_sel_lane14)
	);
	lane_pattern_gate u_gate15 (
		.aclk(aclk),
		.aresetn(aresetn),
		.independent_pattern_select(independent_pattern_select),
		.prbs_en(lane_prbs_pattern_hpf_ctrl[`PRBS_LO+1]),
		.pattern_sel(input_pair_pattern_ctrl[`PAT15_HI:`PAT15_LO]),
		.prbs_active(lane_prbs_active[2]),
		.pattern_active(lane_pattern_active[2]),
		.pattern_out(test_pattern_sel_lane15)
	);
	lane_pattern_gate u_gate16 (
		.aclk(aclk),
		.aresetn(aresetn),
		.independent_pattern_select(independent_pattern_select),
		.prbs_en(lane_prbs_pattern_hpf_ctrl[`PRBS_LO]),
		.pattern_sel(input_pair_pattern_ctrl[`PAT16_HI:`PAT16_LO]),
		.prbs_active(lane_prbs_active[3]),
		.pattern_active(lane_pattern_active[3]),
		.pattern_out(test_pattern_sel_lane16)
	);

	// Input pair steering, one instance per converter
	input_pair_steer #(.PAIR_BASE(`PAIR_BASE13)) u_steer13 (
		.aclk(aclk),
		.aresetn(aresetn),
		.sixteen_input_mode(sixteen_input_mode),
		.pair_sel(input_pair_pattern_ctrl[`PAIR_HI]),
		.pair_num(input_pair_conv13)
	);
	input_pair_steer #(.PAIR_BASE(`PAIR_BASE14)) u_steer14 (
		.aclk(aclk),
		.aresetn(aresetn),
		.sixteen_input_mode(sixteen_input_mode),
		.pair_sel(input_pair_pattern_ctrl[`PAIR_HI-1]),
		.pair_num(input_pair_conv14)
	);
	input_pair_steer #(.PAIR_BASE(`PAIR_BASE15)) u_steer15 (
		.aclk(aclk),
		.aresetn(aresetn),
		.sixteen_input_mode(sixteen_input_mode),
		.pair_sel(input_pair_pattern_ctrl[`PAIR_LO+1]),
		.pair_num(input_pair_conv15)
	);
	input_pair_steer #(.PAIR_BASE(`PAIR_BASE16)) u_steer16 (
		.aclk(aclk),
		.aresetn(aresetn),
		.sixteen_input_mode(sixteen_input_mode),
		.pair_sel(input_pair_pattern_ctrl[`PAIR_LO]),
		.pair_num(input_pair_conv16)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence write_to_first;
		do_write && wr_hit_a && wstrb_q[0];
	endsequence
	sequence enable_follows;
		##2 highpass_enable_grp4 == $past(wdata_q[`HPF_EN], 2);
	endsequence

	chk_hpf_enable_follow: assert property (write_to_first |-> enable_follows)
		else $error("filter enable did not follow the write");
	chk_hpf_coeff_gate: assert property ((highpass_coeff_k_grp4 != 4'h0) |-> highpass_enable_grp4)
		else $error("coefficient reached datapath with filter off");
	chk_coeff_pass_on: assert property (highpass_enable_grp4 |->
		highpass_coeff_k_grp4 == $past(coeff_k))
		else $error("coefficient not passed on as written");
	chk_reserved_zero: assert property (lane_prbs_pattern_hpf_ctrl[5] == 1'b0
		&& input_pair_pattern_ctrl[15:12] == 4'h0 && input_pair_pattern_ctrl[1:0] == 2'h0)
		else $error("reserved bit stored as one");
	chk_write_response: assert property (do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response missing");
	chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid [*1] ##0 !s_axi_arready)
		else $error("read answer late");
endmodule

// file: dv/lane_hpf_cfg_regs_test.sv
// Self-checking bench for the lanes 13-16 pattern, filter and input pair slice
`timescale 1ns/1ps
`include "lane_cfg_defs.svh"
module lane_hpf_cfg_regs_test
	import lane_cfg_pkg::*;
;
	localparam logic [11:0] a_first = {`IDX_PRBS_HPF, 2'b00};
	localparam logic [11:0] a_second = {`IDX_PAIR_PAT, 2'b00};
	localparam logic [11:0] a_stat = {`IDX_STATUS, 2'b00};
	logic aclk;
	logic aresetn;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic ind;
	logic six;
	logic [3:0] prbs_act;
	logic [3:0] pat_act;
	logic [3:0] k_out;
	logic hpf_en;
	pattern_sel_t p13, p14, p15, p16;
	pair_num_t q13, q14, q15, q16;
	int error_cnt;
	int num_checks;

	lane_hpf_cfg_regs dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.independent_pattern_select(ind), .sixteen_input_mode(six),
		.lane_prbs_active(prbs_act), .lane_pattern_active(pat_act),
		.test_pattern_sel_lane13(p13), .test_pattern_sel_lane14(p14),
		.test_pattern_sel_lane15(p15), .test_pattern_sel_lane16(p16),
		.highpass_enable_grp4(hpf_en), .highpass_coeff_k_grp4(k_out),
		.input_pair_conv13(q13), .input_pair_conv14(q14),
		.input_pair_conv15(q15), .input_pair_conv16(q16)
	);

	// Free-running 100 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Compare one value, four-state exact
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Write one word; waits are bounded so a stuck slave ends the run
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		if (bvalid !== 1'b1)
		begin
			chk("write timeout", 32'h1, 32'h0);
			complete_run();
		end
		else
		begin
			chk("bresp", 32'(er), 32'(bresp));
			bready <= 1'b0;
		end
	endtask

	// Read one word and compare data and response
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		if (rvalid !== 1'b1)
		begin
			chk("read timeout", 32'h1, 32'h0);
			complete_run();
		end
		else
		begin
			chk(nm, ed, rdata);
			chk("rresp", 32'(er), 32'(rresp));
			rready <= 1'b0;
		end
	endtask

	// Outputs trail the register or input by one edge; three edges is safe
	task automatic settle();
		repeat (3) @(posedge aclk);
	endtask

	logic [3:0] ks [4] = '{4'h1, 4'h2, 4'ha, 4'hb};
	pattern_sel_t p;

	// Main sequence
	initial
	begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, ind, six} = 7'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h00000000;
		wstrb = 4'h0;
		error_cnt = 0;
		num_checks = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd("first", a_first, 32'h0, `RESP_OKAY);
		rd("second", a_second, 32'h0, `RESP_OKAY);
		chk("hpf_en", 32'h0, 32'(hpf_en));
		rd("status", a_stat, 32'h1, `RESP_OKAY);
		// Reserved bits are dropped and flagged
		wr(a_first, 16'hffff, 4'h3, `RESP_OKAY);
		rd("first", a_first, 32'hffdf, `RESP_OKAY);
		rd("status", a_stat, 32'h3, `RESP_OKAY);
		wr(a_stat, 16'h0002, 4'h3, `RESP_OKAY);
		wr(a_second, 16'hffff, 4'h3, `RESP_OKAY);
		rd("second", a_second, 32'h0ffc, `RESP_OKAY);
		rd("status", a_stat, 32'h3, `RESP_OKAY);
		wr(a_stat, 16'h0002, 4'h3, `RESP_OKAY);
		// Coefficient at both edges of its legal range
		foreach (ks[i])
		begin
			wr(a_first, {11'h000, ks[i], 1'b1}, 4'h3, `RESP_OKAY);
			settle();
			chk("coeff", 32'(ks[i]), 32'(k_out));
			chk("hpf_en", 32'h1, 32'(hpf_en));
			rd("status", a_stat, 32'(ks[i] < 4'h2 || ks[i] > 4'ha), `RESP_OKAY);
		end
		wr(a_first, 16'h0016, 4'h3, `RESP_OKAY);
		settle();
		chk("coeff off", 32'h0, 32'(k_out));
		chk("hpf_en", 32'h0, 32'(hpf_en));
		// Lane enables and selects held back until independent selection
		wr(a_first, 16'haacf, 4'h3, `RESP_OKAY);
		settle();
		chk("prbs", 32'h0, 32'(prbs_act));
		chk("pat13", 32'h0, 32'(p13));
		ind <= 1'b1;
		settle();
		chk("prbs", 32'h5, 32'(prbs_act));
		chk("pat act", 32'hf, 32'(pat_act));
		chk("pat13", 32'h5, 32'(p13));
		chk("pat14", 32'h3, 32'(p14));
		chk("coeff", 32'h7, 32'(k_out));
		rd("status", a_stat, 32'h4, `RESP_OKAY);
		// Every pattern code on every lane
		for (int i = 0; i < 8; i++)
		begin
			p = 3'(i);
			wr(a_first, {4'h0, p, ~p, 6'h00}, 4'h3, `RESP_OKAY);
			wr(a_second, {8'h00, p, ~p, 2'b00}, 4'h3, `RESP_OKAY);
			settle();
			chk("pat13", 32'(p), 32'(p13));
			chk("pat14", {29'h0, ~p}, 32'(p14));
			chk("pat15", 32'(p), 32'(p15));
			chk("pat16", {29'h0, ~p}, 32'(p16));
		end
		ind <= 1'b0;
		settle();
		chk("pat15", 32'h0, 32'(p15));
		// Byte strobes: only the high byte lands
		wr(a_first, 16'h00c5, 4'h3, `RESP_OKAY);
		wr(a_first, 16'h33ff, 4'h2, `RESP_OKAY);
		rd("first", a_first, 32'h33c5, `RESP_OKAY);
		// Input pair steering
		wr(a_second, 16'h0a00, 4'h3, `RESP_OKAY);
		settle();
		chk("pair13", 32'h0, 32'(q13));
		six <= 1'b1;
		settle();
		chk("pair13", 32'h1a, 32'(q13));
		chk("pair14", 32'h1b, 32'(q14));
		chk("pair15", 32'h1e, 32'(q15));
		chk("pair16", 32'h1f, 32'(q16));
		wr(a_second, 16'h0500, 4'h3, `RESP_OKAY);
		settle();
		chk("pair13", 32'h19, 32'(q13));
		chk("pair14", 32'h1c, 32'(q14));
		chk("pair15", 32'h1d, 32'(q15));
		chk("pair16", 32'h20, 32'(q16));
		rd("status", a_stat, 32'h8, `RESP_OKAY);
		// Unmapped and misaligned places answer with an error
		wr(12'h0e8, 16'hffff, 4'h3, `RESP_SLVERR);
		rd("unmapped", 12'h0e8, 32'h0, `RESP_SLVERR);
		wr(12'h0e5, 16'h0000, 4'h3, `RESP_SLVERR);
		rd("misaligned", 12'h0e5, 32'h0, `RESP_SLVERR);
		rd("first", a_first, 32'h33c5, `RESP_OKAY);
		complete_run();
	end
endmodule
